/* File: pkg/oos_pkg.sv */
// oos_pkg: constants shared by the oversampled output sequencer.
// assumes a 20 MHz core clock; times are converted to clock counts here.
package oos_pkg;
  // =====================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MIN_MICRO_NS = 1000;
  // least microcycle, rounded up to whole clocks
  localparam int unsigned MIN_MICRO_CYC = (MIN_MICRO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_DEV_NS = 100;
  // longest deviation, rounded down to whole clocks
  localparam int unsigned SYNC_DEV_CYC = SYNC_DEV_NS / CLK_PERIOD_NS;
  localparam int unsigned WDOG_MS = 100;
  localparam int unsigned WDOG_CYC = WDOG_MS * (CLK_HZ / 1000);
  // =====================================================
  // factor and process image limits
  localparam int unsigned MAX_FACTOR = 1000;
  localparam int unsigned MAX_OUT_BYTES = 504;
  localparam int unsigned MAX_IN_BYTES = 4;
  localparam int unsigned NUM_CHAN = 2;
  localparam int unsigned FIFO_DEPTH = 8;
  // reset level of the outputs
  localparam logic [1:0] OUT_RESET = 2'h0;
  // =====================================================
  // sequencer states
  typedef enum logic [1:0] {
    OOS_IDLE = 2'b00,
    OOS_WAIT = 2'b01,
    OOS_PLAY = 2'b10
  } oos_state_t;
endpackage : oos_pkg

/* File: rtl/oos_fifo.sv */
// oos_fifo: small synchronous FIFO with valid/ready on both sides.
// assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module oos_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // read side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("fifo depth must be a power of two");
  end
  // =====================================================
  // storage and pointers, one extra bit tells full from empty
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, rd_q;
  logic [WIDTH-1:0] dout_q;
  logic vld_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire do_wr = in_valid && !full;
  // output register refills when empty or being drained
  wire do_rd = !empty && (!vld_q || out_ready);
  assign in_ready = !full;
  assign out_valid = vld_q;
  assign out_data = dout_q;
  // write port
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  // pointers and registered read data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      vld_q <= 1'b0;
      dout_q <= '0;
    end else begin
      if (do_wr) wr_q <= wr_q + 1'b1;
      if (do_rd) begin
        rd_q <= rd_q + 1'b1;
        dout_q <= mem_q[rd_q[AW-1:0]];
        vld_q <= 1'b1;
      end else if (out_ready) begin
        vld_q <= 1'b0;
      end
    end
  end
endmodule // oos_fifo
`default_nettype wire

/* File: rtl/oos_sequencer.sv */
// oos_sequencer: plays one block of samples per bus cycle out as n microcycles.
// assumes the process data arrives as a stream of per-microcycle samples and a
// bus cycle start pulse derived from the system time sync.
`timescale 1ns/1ps
`default_nettype none
module oos_sequencer
  import oos_pkg::*;
#(
  parameter int unsigned FACTOR_W = 10,
  parameter int unsigned PERIOD_W = 24,
  parameter int unsigned WDOG_W = 24,
  parameter int unsigned WDOG_LIMIT = WDOG_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // configuration
  input wire logic [FACTOR_W-1:0] FACTOR,
  input wire logic [PERIOD_W-1:0] MICRO_PERIOD,
  input wire logic SINGLE_CHAN,
  input wire logic WDOG_ENABLE,
  // system time sync
  input wire logic SYNC_PULSE,
  // process data sample stream
  input wire logic SAMPLE_VALID,
  output logic SAMPLE_READY,
  input wire logic [NUM_CHAN-1:0] SAMPLE_DATA,
  input wire logic PD_EXCHANGE,
  // outputs and status
  output logic [NUM_CHAN-1:0] DOUT,
  output logic WDOG_TRIPPED,
  output logic UNDERRUN,
  output logic CONFIG_ERROR
);
  initial begin
    if (FACTOR_W < 10 || WDOG_W < $clog2(WDOG_LIMIT + 1)) $error("widths too narrow");
  end
  // =====================================================
  // buffering of incoming samples
  logic fifo_valid, fifo_ready, accept;
  logic [NUM_CHAN-1:0] fifo_data;
  oos_fifo #(.WIDTH(NUM_CHAN), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(accept),
    .in_ready(),
    .in_data(SAMPLE_DATA),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );
  // =====================================================
  // configuration checks
  localparam logic [FACTOR_W-1:0] FMAX = FACTOR_W'(MAX_FACTOR);
  localparam logic [PERIOD_W-1:0] PMIN = PERIOD_W'(MIN_MICRO_CYC);
  localparam logic [FACTOR_W-1:0] BYTES_PER_CH = FACTOR_W'(MAX_OUT_BYTES / NUM_CHAN);
  // whole-byte samples per channel cap the factor for the process image
  wire factor_bad = (FACTOR == '0) || (FACTOR > FMAX) || (FACTOR > BYTES_PER_CH);
  wire period_bad = (MICRO_PERIOD < PMIN);
  wire cfg_bad = factor_bad || period_bad;
  // channel two is masked in single channel mode
  wire [NUM_CHAN-1:0] chan_mask = SINGLE_CHAN ? 2'h1 : 2'h3;
  // =====================================================
  // state
  oos_state_t state_q, state_d;
  logic [PERIOD_W-1:0] tick_q, tick_d;
  logic [FACTOR_W-1:0] idx_q, idx_d;
  logic [NUM_CHAN-1:0] dout_q, dout_d;
  logic [WDOG_W-1:0] wd_q, wd_d;
  logic trip_q, trip_d;
  logic under_q, under_d;
  logic cfg_q;
  // microcycle boundary: the period counter expires
  wire tick_end = (tick_q == MICRO_PERIOD - 1'b1);
  wire last_micro = (idx_q == FACTOR - 1'b1);
  // sample is taken from the buffer exactly at an update instant
  // the end of the last microcycle is no update: n updates per bus cycle
  wire update = (state_q == OOS_PLAY) && (SYNC_PULSE || (tick_end && !last_micro))
    && !cfg_bad;
  wire first_update = (state_q != OOS_IDLE) && SYNC_PULSE && !cfg_bad;
  wire take = (update || first_update) && fifo_valid && !trip_q;
  assign fifo_ready = take;
  // =====================================================
  // next state: a sync pulse in WAIT or PLAY restarts the bus cycle at microcycle 0
  always_comb begin
    state_d = state_q;
    tick_d = tick_q;
    idx_d = idx_q;
    dout_d = dout_q;
    under_d = 1'b0;
    unique case (state_q)
      OOS_IDLE: begin
        state_d = cfg_bad ? OOS_IDLE : OOS_WAIT;
      end
      OOS_WAIT: begin
        if (cfg_bad) begin
          state_d = OOS_IDLE;
        end else if (SYNC_PULSE) begin
          state_d = OOS_PLAY;
          tick_d = '0;
          idx_d = '0;
        end
      end
      OOS_PLAY: begin
        if (cfg_bad) begin
          state_d = OOS_IDLE;
        end else if (SYNC_PULSE) begin
          tick_d = '0;
          idx_d = '0;
        end else if (tick_end) begin
          tick_d = '0;
          if (last_micro) begin
            state_d = OOS_WAIT; // wait for next bus cycle start
          end else begin
            idx_d = idx_q + 1'b1;
          end
        end else begin
          tick_d = tick_q + 1'b1;
        end
      end
      default: state_d = OOS_IDLE;
    endcase
    // new sample or hold last value
    if ((update || (state_q == OOS_WAIT && SYNC_PULSE && !cfg_bad)) && !trip_q) begin
      if (fifo_valid) begin
        dout_d = fifo_data & chan_mask;
      end else begin
        under_d = 1'b1; // keep last value when data is late
      end
    end
    // channel two drops at once when single mode is chosen
    dout_d = dout_d & chan_mask;
    if (trip_d || state_d == OOS_IDLE) begin
      dout_d = OUT_RESET;
    end
  end
  // process data watchdog, restarted by every exchange
  always_comb begin
    wd_d = wd_q;
    trip_d = trip_q;
    if (PD_EXCHANGE) begin
      wd_d = '0;
      trip_d = 1'b0;
    end else if (WDOG_ENABLE && !trip_q) begin
      if (wd_q == WDOG_W'(WDOG_LIMIT - 1)) begin
        trip_d = 1'b1;
      end else begin
        wd_d = wd_q + 1'b1;
      end
    end
  end
  // registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= OOS_IDLE;
      tick_q <= '0;
      idx_q <= '0;
      dout_q <= OUT_RESET;
      wd_q <= '0;
      trip_q <= 1'b0;
      under_q <= 1'b0;
      cfg_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tick_q <= tick_d;
      idx_q <= idx_d;
      dout_q <= dout_d;
      wd_q <= wd_d;
      trip_q <= trip_d;
      under_q <= under_d;
      cfg_q <= cfg_bad;
    end
  end
  // =====================================================
  // buffer occupancy, kept here so that ready comes straight from a flop;
  // the output register is counted too, so one buffer slot stays unused
  localparam int unsigned OCC_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [OCC_W-1:0] OCC_ONE = OCC_W'(1);
  localparam logic [OCC_W-1:0] OCC_FULL = OCC_W'(FIFO_DEPTH);
  logic [OCC_W-1:0] occ_q;
  logic rdy_q;
  wire pop = fifo_valid && fifo_ready;
  // only words the master sees taken enter the buffer, so none is doubled
  assign accept = SAMPLE_VALID && rdy_q;
  wire [OCC_W-1:0] occ_up = occ_q + OCC_ONE;
  wire [OCC_W-1:0] occ_dn = occ_q - OCC_ONE;
  wire [OCC_W-1:0] occ_d = (accept && !pop) ? occ_up : ((pop && !accept) ? occ_dn : occ_q);
  // ready for the next edge: room left after this edge's traffic
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      occ_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      occ_q <= occ_d;
      rdy_q <= (occ_d < OCC_FULL);
    end
  end
  assign SAMPLE_READY = rdy_q;
  assign DOUT = dout_q;
  assign WDOG_TRIPPED = trip_q;
  assign UNDERRUN = under_q;
  assign CONFIG_ERROR = cfg_q;
endmodule // oos_sequencer
`default_nettype wire

/* File: tb/oos_sequencer_chk.sv */
// oos_sequencer_chk: port timing checks for the sequencer.
// assumes a bind onto oos_sequencer with its parameters.
`timescale 1ns/1ps
`default_nettype none
module oos_sequencer_chk #(
  parameter int unsigned PERIOD_W = 24,
  parameter int unsigned WDOG_LIMIT = 50
) (
  // clock, reset, config
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [PERIOD_W-1:0] MICRO_PERIOD,
  input wire logic SINGLE_CHAN,
  input wire logic WDOG_ENABLE,
  // sync and exchange
  input wire logic SYNC_PULSE,
  input wire logic PD_EXCHANGE,
  // outputs
  input wire logic [1:0] DOUT,
  input wire logic WDOG_TRIPPED,
  input wire logic UNDERRUN,
  input wire logic CONFIG_ERROR
);
  // ====
  // clocks since sync and since last exchange
  logic [PERIOD_W-1:0] tick_q;
  logic [31:0] idle_q;
  wire logic on_tick = (tick_q % MICRO_PERIOD) == '0;
  always_ff @(posedge CLK) begin
    tick_q <= (!RST_N || SYNC_PULSE) ? '0 : tick_q + 1'b1;
    idle_q <= (!RST_N || PD_EXCHANGE || !WDOG_ENABLE) ? '0 : idle_q + 1'b1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ====
  // checks
  a_single_chan_off: assert property (SINGLE_CHAN && $past(SINGLE_CHAN) |-> !DOUT[1])
    else $error("channel two on in single mode");
  a_trip_outputs_off: assert property (WDOG_TRIPPED && $past(WDOG_TRIPPED) |-> DOUT == 2'h0)
    else $error("outputs on while tripped");
  a_cfg_outputs_off: assert property (CONFIG_ERROR && $past(CONFIG_ERROR) |-> DOUT == 2'h0)
    else $error("outputs on with bad config");
  a_update_on_tick: assert property ($changed(DOUT) && !WDOG_TRIPPED && !CONFIG_ERROR
    && $past(SINGLE_CHAN) == $past(SINGLE_CHAN, 2) |-> on_tick)
    else $error("output changed between updates");
  a_underrun_on_tick: assert property (UNDERRUN |-> on_tick)
    else $error("underrun off an update");
  a_underrun_one_pulse: assert property (UNDERRUN |=> !UNDERRUN)
    else $error("underrun longer than a cycle");
  a_trip_on_time: assert property ($rose(WDOG_TRIPPED)
    |-> idle_q >= WDOG_LIMIT - 1 && idle_q <= WDOG_LIMIT + 1)
    else $error("watchdog tripped at wrong time");
  a_exchange_clears_trip: assert property (PD_EXCHANGE |=> !WDOG_TRIPPED)
    else $error("exchange left trip set");
endmodule // oos_sequencer_chk
`default_nettype wire

/* File: tb/oos_master.sv */
// oos_master: fieldbus side feeding samples and bus cycle starts.
// assumes the bench queues words by push and starts cycles by start.
`timescale 1ns/1ps
`default_nettype none
module oos_master (
  // clock and handshake
  input wire logic clk,
  input wire logic ready,
  // toward the device
  output logic valid,
  output logic [1:0] data,
  output logic sync,
  output logic exch
);
  logic [1:0] q[$];
  logic [1:0] pend;
  logic took;
  task automatic push(input logic [1:0] w);
    q.push_back(w);
  endtask
  task automatic start(input logic [1:0] how);
    pend = how;
  endtask
  // ====
  // word held until taken; idle data toggles so it is never stale
  initial {valid, data, sync, exch, pend, took} = '0;
  always @(posedge clk) took <= valid && ready;
  always @(negedge clk) begin
    if (took) void'(q.pop_front());
    {sync, exch} = pend;
    pend = 2'h0;
    valid = q.size() > 0;
    data = valid ? q[0] : ~data;
  end
endmodule // oos_master
`default_nettype wire

/* File: tb/oversampled_output_sequencer_tb.sv */
// oversampled_output_sequencer_tb: directed tests of the sequencer.
// assumes oos_master as fieldbus side and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module oversampled_output_sequencer_tb;
  import oos_pkg::*;
  localparam int P = 20;
  localparam int WD = 200;
  logic clk, rst_n, single, wden, sync, valid, ready, exch, trip, under, cerr;
  logic [9:0] factor;
  logic [1:0] data, dout;
  logic [23:0] period;
  int fails, check_count;
  // microcycle of 1 us keeps the master at 1 Msample/s
  oos_sequencer #(.WDOG_LIMIT(WD)) u_dut (.CLK(clk), .RST_N(rst_n), .FACTOR(factor),
    .MICRO_PERIOD(period), .SINGLE_CHAN(single), .WDOG_ENABLE(wden), .SYNC_PULSE(sync),
    .SAMPLE_VALID(valid), .SAMPLE_READY(ready), .SAMPLE_DATA(data), .PD_EXCHANGE(exch),
    .DOUT(dout), .WDOG_TRIPPED(trip), .UNDERRUN(under), .CONFIG_ERROR(cerr));
  oos_master u_m (.clk(clk), .ready(ready), .valid(valid), .data(data), .sync(sync),
    .exch(exch));
  // ====
  // helpers
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic cycle();
    u_m.start(2'h3);
    @(posedge clk iff sync);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_cfg();
    factor = 10'h0;
    tick(2);
    chk({1'b0, cerr}, 2'h1);
    factor = 10'(MAX_OUT_BYTES / NUM_CHAN + 1);
    tick(2);
    chk({1'b0, cerr}, 2'h1);
    factor = 10'h3;
    period = 24'(MIN_MICRO_CYC - 1);
    tick(2);
    chk({1'b0, cerr}, 2'h1);
    period = 24'(P);
    tick(2);
    chk({1'b0, cerr}, 2'h0);
    $display("config done");
  endtask
  task automatic t_play(input logic s, input int p);
    logic [1:0] m;
    m = s ? 2'h1 : 2'h3;
    single = s;
    period = 24'(p);
    u_m.push(2'h1);
    u_m.push(2'h2);
    u_m.push(2'h3);
    // let the first word reach the buffer's output before the cycle starts
    tick(4);
    cycle();
    @(negedge clk);
    chk(dout, 2'h1 & m);
    chk({1'b0, under}, 2'h0);
    tick(p - 1);
    chk(dout, 2'h1 & m);
    tick(1);
    chk(dout, 2'h2 & m);
    tick(p);
    chk(dout, 2'h3 & m);
    tick(p);
    chk(dout, 2'h3 & m);
    single = 1'b0;
    period = 24'(P);
    $display("play done");
  endtask
  task automatic t_under();
    cycle();
    @(negedge clk);
    chk({1'b0, under}, 2'h1);
    chk({1'b0, dout[0]}, 2'h1);
    tick(1);
    chk({1'b0, under}, 2'h0);
    tick(3 * P);
    $display("underrun done");
  endtask
  task automatic t_fill();
    for (int i = 0; i < 12; i++) u_m.push(2'(i));
    tick(20);
    chk({1'b0, ready}, 2'h0);
    chk({1'b0, u_m.q.size() <= 12 - FIFO_DEPTH}, 2'h1);
    repeat (4) begin
      cycle();
      tick(3 * P);
    end
    chk(dout, 2'h3);
    chk({1'b0, ready}, 2'h1);
    $display("fill done");
  endtask
  task automatic t_wdog();
    wden = 1'b1;
    tick(WD + 5);
    chk({1'b0, trip}, 2'h1);
    chk(dout, 2'h0);
    u_m.start(2'h1);
    tick(2);
    chk({1'b0, trip}, 2'h0);
    wden = 1'b0;
    $display("watchdog done");
  endtask
  // ====
  // clock, main sequence, hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst_n, single, wden} = '0;
    factor = 10'h3;
    period = 24'(P);
    fails = 0;
    check_count = 0;
    tick(2);
    rst_n = 1'b1;
    tick(2);
    t_cfg();
    t_play(1'b0, P);
    t_play(1'b1, P);
    t_under();
    t_fill();
    t_play(1'b0, 10 * P);
    t_wdog();
    wrap_up();
  end
  // whole run is about 1300 cycles
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule // oversampled_output_sequencer_tb
bind oos_sequencer oos_sequencer_chk #(.PERIOD_W(PERIOD_W), .WDOG_LIMIT(WDOG_LIMIT)) u_chk (
  .CLK(CLK), .RST_N(RST_N), .MICRO_PERIOD(MICRO_PERIOD), .SINGLE_CHAN(SINGLE_CHAN),
  .WDOG_ENABLE(WDOG_ENABLE), .SYNC_PULSE(SYNC_PULSE), .PD_EXCHANGE(PD_EXCHANGE),
  .DOUT(DOUT), .WDOG_TRIPPED(WDOG_TRIPPED), .UNDERRUN(UNDERRUN), .CONFIG_ERROR(CONFIG_ERROR));
`default_nettype wire
